// ===== rtl/adc_cmp_pkg.sv
// Behaviour
// - mode or channel write may corrupt result
// - select mode compares threshold to chosen high byte
// - select match stores result, raises interrupt
// - scan mode compares threshold to channel 0
// - scan channel 0 match stores, raises interrupt
// - scan continues storing every non-zero channel result regardless of match
// - no interrupt at scan completion while compare is enabled
package adc_cmp_pkg;
    // ****************************************
    // widths and layout
    // ****************************************
    localparam int RES_W    = 10;
    localparam int CH_W     = 4;
    localparam int NUM_CH   = 16;
    localparam int SEL_W    = 8;
    localparam int SEL_CH_LSB = 0;
    localparam int HI_LSB   = 2;
    localparam logic [RES_W-1:0] RESULT_RST = 10'h000;
    localparam logic [7:0]       THRESH_RST = 8'h00;
    localparam logic [CH_W-1:0]  CH0        = 4'h0;
    // compare condition codes
    localparam logic CMP_GE = 1'b0;
    localparam logic CMP_LT = 1'b1;
endpackage : adc_cmp_pkg

// ===== rtl/adc_result_compare_control.sv
module adc_result_compare_control (
    input  wire logic                          ref_clk,
    input  wire logic                          rstn,
    input  wire logic                          conversionEnable,
    input  wire logic                          scanMode,
    input  wire logic                          compareEnable,
    input  wire logic                          compareConditionBit,
    input  wire logic [7:0]                    compareThreshold,
    input  wire logic [adc_cmp_pkg::SEL_W-1:0] channelSelect,
    input  wire logic                          modeWrite,
    input  wire logic                          convDone,
    input  wire logic [adc_cmp_pkg::CH_W-1:0]  convChannel,
    input  wire logic [adc_cmp_pkg::RES_W-1:0] convData,
    input  wire logic                          scanLast,
    input  wire logic [adc_cmp_pkg::CH_W-1:0]  readChannel,
    output logic [adc_cmp_pkg::RES_W-1:0]      convResultReg,
    output logic [7:0]                         convResultHighByte,
    output logic                               resultValid,
    output logic                               conversionEndIrq
);
    // ****************************************
    // result storage
    // ****************************************
    logic [adc_cmp_pkg::RES_W-1:0] result_q [adc_cmp_pkg::NUM_CH];
    logic [adc_cmp_pkg::NUM_CH-1:0] valid_q;
    logic [7:0] dataHigh;
    logic       match;
    logic [adc_cmp_pkg::CH_W-1:0] selCh;
    logic       isSelCh;
    logic       isCh0;
    logic       storeSel;
    logic       gate;

    function automatic logic [7:0] high_of(
        input logic [adc_cmp_pkg::RES_W-1:0] v);
        high_of = v[adc_cmp_pkg::RES_W-1:adc_cmp_pkg::HI_LSB];
    endfunction : high_of

    assign selCh = channelSelect[adc_cmp_pkg::SEL_CH_LSB +: adc_cmp_pkg::CH_W];
    assign dataHigh = high_of(convData);
    assign isSelCh = convChannel == selCh;
    assign isCh0 = convChannel == adc_cmp_pkg::CH0;

    adc_threshold_cmp u_cmp (
        .highByte  (dataHigh),
        .threshold (compareThreshold),
        .condLess  (compareConditionBit),
        .match     (match)
    );

    // ****************************************
    // compare gating
    // ****************************************
    // compare gating: select checks chosen channel, scan checks channel 0
    always_comb begin
        if (!compareEnable) begin
            gate = 1'b1;
        end else if (scanMode) begin
            gate = isCh0 ? match : 1'b0;
        end else begin
            gate = isSelCh && match;
        end
    end

    // in scan every channel except compared channel 0 is stored; select with compare on stores only on match
    assign storeSel = convDone && conversionEnable &&
                      (scanMode ? (!isCh0 || !compareEnable || gate) : gate);

    // channel 0 in scan with compare also only stored on match
    generate
        for (genvar i = 0; i < adc_cmp_pkg::NUM_CH; i++) begin : g_res
            always_ff @(posedge ref_clk) begin
                if (!rstn) begin
                    result_q[i] <= adc_cmp_pkg::RESULT_RST;
                end else if (storeSel &&
                             convChannel == adc_cmp_pkg::CH_W'(i)) begin
                    result_q[i] <= convData;
                end
            end
        end
    endgenerate

    // validity drops on mode/channel writes; content then undefined
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            valid_q <= '0;
        end else if (modeWrite) begin
            valid_q <= '0;
        end else if (storeSel) begin
            valid_q[convChannel] <= 1'b1;
        end
    end

    // ****************************************
    // interrupt
    // ****************************************
    // with compare on, scan end never interrupts; only the gated compare does
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            conversionEndIrq <= 1'b0;
        end else if (convDone && conversionEnable && compareEnable) begin
            if (scanMode) begin
                conversionEndIrq <= isCh0 && gate;
            end else begin
                conversionEndIrq <= gate;
            end
        end else if (convDone && conversionEnable) begin
            // ordinary scan raises at its last channel only
            conversionEndIrq <= scanMode ? scanLast : 1'b1;
        end else begin
            conversionEndIrq <= 1'b0;
        end
    end

    // ****************************************
    // read port
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            convResultReg      <= adc_cmp_pkg::RESULT_RST;
            convResultHighByte <= high_of(adc_cmp_pkg::RESULT_RST);
            resultValid        <= 1'b0;
        end else begin
            convResultReg      <= result_q[readChannel];
            convResultHighByte <= high_of(result_q[readChannel]);
            resultValid        <= valid_q[readChannel];
        end
    end

    // ****************************************
    // checks
    // ****************************************
    sel_miss_a: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        convDone && conversionEnable && compareEnable && !scanMode && !gate
        |=> !conversionEndIrq)
        else $error("select miss raised interrupt");

    sel_hit_a: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        convDone && conversionEnable && compareEnable && !scanMode && gate
        |=> conversionEndIrq)
        else $error("select match no interrupt");

    sel_chan_a: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        convDone && conversionEnable && compareEnable && !scanMode && !isSelCh
        |=> !conversionEndIrq)
        else $error("unselected channel interrupted");

    sel_store_a: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        convDone && conversionEnable && compareEnable && !scanMode && gate
        |=> result_q[$past(convChannel)] == $past(convData))
        else $error("select match not stored");

    sel_keep_a: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        convDone && conversionEnable && compareEnable && !scanMode && !gate
        |=> result_q[$past(convChannel)] == $past(result_q[convChannel]))
        else $error("select miss overwrote result");

    scan_other_a: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        convDone && conversionEnable && compareEnable && scanMode && !isCh0
        |=> !conversionEndIrq)
        else $error("scan non-zero channel interrupted");

    scan_ch0_a: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        convDone && conversionEnable && compareEnable && scanMode && isCh0
        |=> conversionEndIrq == $past(match))
        else $error("channel 0 compare wrong");

    scan_keep_a: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        convDone && conversionEnable && compareEnable && scanMode && isCh0 &&
        !match |=> result_q[0] == $past(result_q[0]))
        else $error("channel 0 miss overwrote result");

    scan_store_a: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        convDone && conversionEnable && scanMode && !isCh0 && !modeWrite
        |=> valid_q[$past(convChannel)])
        else $error("scan result not stored");

    scan_data_a: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        convDone && conversionEnable && scanMode && !isCh0
        |=> result_q[$past(convChannel)] == $past(convData))
        else $error("scan result data wrong");

    plain_irq_a: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        convDone && conversionEnable && !compareEnable && !scanMode
        |=> conversionEndIrq)
        else $error("plain conversion no interrupt");

    plain_store_a: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        convDone && conversionEnable && !compareEnable
        |=> result_q[$past(convChannel)] == $past(convData))
        else $error("plain result not stored");

    mode_clear_a: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        modeWrite
        |=> valid_q == '0)
        else $error("valid kept after mode write");

    idle_irq_a: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        !(convDone && conversionEnable)
        |=> !conversionEndIrq)
        else $error("interrupt without conversion");

    sel_cov: cover property (@(posedge ref_clk)
        compareEnable && !scanMode && conversionEndIrq);
    scan_cov: cover property (@(posedge ref_clk)
        compareEnable && scanMode && conversionEndIrq);
    mode_cov: cover property (@(posedge ref_clk) modeWrite && valid_q != '0);
    plain_cov: cover property (@(posedge ref_clk)
        !compareEnable && scanMode && conversionEndIrq);
    skip_cov: cover property (@(posedge ref_clk)
        convDone && conversionEnable && compareEnable && !gate);
endmodule : adc_result_compare_control

// ===== rtl/adc_threshold_cmp.sv
module adc_threshold_cmp (
    input  wire logic [7:0] highByte,
    input  wire logic [7:0] threshold,
    input  wire logic       condLess,
    output logic            match
);
    // condition bit picks at-or-above vs below threshold
    always_comb begin
        if (condLess == adc_cmp_pkg::CMP_LT) begin
            match = highByte < threshold;
        end else begin
            match = highByte >= threshold;
        end
    end
endmodule : adc_threshold_cmp

// ===== testbench/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic scan, cmp, cond, last, irq, st;
        logic [7:0] thr;
        logic [3:0] sel, ch;
        logic [9:0] data;
    } row_t;
    logic       ref_clk = 1'b0, rstn = 1'b0, conversionEnable = 1'b0;
    logic       scanMode = 1'b0, compareEnable = 1'b0, modeWrite = 1'b0;
    logic       compareConditionBit = 1'b0, convDone = 1'b0, scanLast = 1'b0;
    logic [7:0] compareThreshold = 8'h00, channelSelect = 8'h00;
    logic [3:0] convChannel = 4'h0, readChannel = 4'h0;
    logic [9:0] convData = 10'h000, convResultReg, expRes [16];
    logic [7:0] convResultHighByte;
    logic       resultValid, conversionEndIrq;
    int         n_fail = 0, num_checks = 0, cycles = 0;
    row_t       rows [12];
    adc_result_compare_control dut_u (.ref_clk(ref_clk), .rstn(rstn),
        .conversionEnable(conversionEnable), .scanMode(scanMode),
        .compareEnable(compareEnable), .modeWrite(modeWrite),
        .compareConditionBit(compareConditionBit), .convDone(convDone),
        .compareThreshold(compareThreshold), .channelSelect(channelSelect),
        .convChannel(convChannel), .convData(convData), .scanLast(scanLast),
        .readChannel(readChannel), .convResultReg(convResultReg),
        .convResultHighByte(convResultHighByte), .resultValid(resultValid),
        .conversionEndIrq(conversionEndIrq));
    always #2 ref_clk = ~ref_clk;
    // ****************************************
    // checking and closing
    // ****************************************
    task automatic check(input string nm, input logic [9:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : summarize
    // whole run is under a hundred cycles; generous ceiling
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            summarize();
        end
    end
    // settings change only while stopped, as software must
    task automatic run(input row_t r, input logic en);
        @(posedge ref_clk); #1;
        conversionEnable = 1'b0;
        {scanMode, compareEnable} = {r.scan, r.cmp};
        compareConditionBit = r.cond;
        compareThreshold = r.thr;
        channelSelect = {4'h0, r.sel};
        @(posedge ref_clk); #1;
        conversionEnable = en;
        @(posedge ref_clk); #1;
        {convChannel, convData, scanLast} = {r.ch, r.data, r.last};
        readChannel = r.ch;
        convDone = 1'b1;
        @(posedge ref_clk); #1;
        convDone = 1'b0;
        check("irq", conversionEndIrq, r.irq);
        if (r.st) expRes[r.ch] = r.data;
        @(posedge ref_clk); #1;
        check("irqPulse", conversionEndIrq, 1'b0);
        check("result", convResultReg, expRes[r.ch]);
        check("highByte", convResultHighByte, expRes[r.ch][9:2]);
        if (r.st) check("valid", resultValid, 1'b1);
    endtask : run
    initial begin
        foreach (expRes[i]) expRes[i] = 10'h000;
        // scan cmp cond last irq st thr sel ch data
        rows = '{'{1'h0,1'h0,1'h0,1'h0,1'h1,1'h1,8'h00,4'h3,4'h3,10'h155},
                 '{1'h0,1'h1,1'h0,1'h0,1'h1,1'h1,8'h40,4'h5,4'h5,10'h100},
                 '{1'h0,1'h1,1'h0,1'h0,1'h0,1'h0,8'h40,4'h5,4'h5,10'h0fc},
                 '{1'h0,1'h1,1'h1,1'h0,1'h1,1'h1,8'h40,4'h5,4'h5,10'h0fc},
                 '{1'h0,1'h1,1'h1,1'h0,1'h0,1'h0,8'h40,4'h5,4'h5,10'h100},
                 '{1'h0,1'h1,1'h0,1'h0,1'h0,1'h0,8'h40,4'h5,4'h6,10'h3ff},
                 '{1'h1,1'h1,1'h0,1'h0,1'h1,1'h1,8'h80,4'h0,4'h0,10'h3ff},
                 '{1'h1,1'h1,1'h0,1'h0,1'h0,1'h0,8'h80,4'h0,4'h0,10'h000},
                 '{1'h1,1'h1,1'h0,1'h0,1'h0,1'h1,8'h80,4'h0,4'h1,10'h200},
                 '{1'h1,1'h1,1'h0,1'h1,1'h0,1'h1,8'h80,4'h0,4'h2,10'h001},
                 '{1'h1,1'h0,1'h0,1'h0,1'h0,1'h1,8'h00,4'h0,4'h4,10'h2aa},
                 '{1'h1,1'h0,1'h0,1'h1,1'h1,1'h1,8'h00,4'h0,4'h7,10'h0ff}};
        repeat (4) @(posedge ref_clk);
        #1 rstn = 1'b1;
        check("rstResult", convResultReg, 10'h000);
        check("rstValid", resultValid, 1'b0);
        check("rstIrq", conversionEndIrq, 1'b0);
        $display("test reset done");
        foreach (rows[i]) run(rows[i], 1'b1);
        $display("test table done");
        // stopped converter ignores a finished conversion
        run(row_t'{1'h0,1'h0,1'h0,1'h0,1'h0,1'h0,8'h00,4'h9,4'h9,10'h3c3},
            1'b0);
        $display("test stopped done");
        // read the stored result first, then write the mode
        @(posedge ref_clk); #1;
        readChannel = 4'h3;
        @(posedge ref_clk); #1;
        check("validBefore", resultValid, 1'b1);
        check("readFirst", convResultReg, expRes[3]);
        modeWrite = 1'b1;
        @(posedge ref_clk); #1;
        modeWrite = 1'b0;
        @(posedge ref_clk); #1;
        check("validClear", resultValid, 1'b0);
        run(rows[2], 1'b1);
        check("validKept", resultValid, 1'b0);
        $display("test mode write done");
        // mid-run reset must also clear the result store
        readChannel = 4'h3;
        rstn = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 rstn = 1'b1;
        check("rstResult2", convResultReg, 10'h000);
        check("rstValid2", resultValid, 1'b0);
        check("rstIrq2", conversionEndIrq, 1'b0);
        @(posedge ref_clk); #1;
        check("rstStore", convResultReg, 10'h000);
        $display("test mid reset done");
        summarize();
    end
endmodule : tb_top
